// ===== core/boundary_scan_chain_control.sv
// Boundary scan register, pin steering and reset handshakes
`timescale 1ns/1ps
module boundary_scan_chain_control
(
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic tck_in,
  input wire logic tms_in,
  input wire logic tdi_in,
  output logic tdo_out,
  output logic tdo_oe_out,
  input wire logic [bscan_pkg::OUT_CELLS-1:0] core_out_in,
  input wire logic [bscan_pkg::OUT_CELLS-1:0] core_oe_in,
  input wire logic [bscan_pkg::IN_CELLS-1:0] pin_in_in,
  output logic [bscan_pkg::OUT_CELLS-1:0] pin_out_out,
  output logic [bscan_pkg::OUT_CELLS-1:0] pin_oe_out,
  input wire logic system_reset_input_n_in,
  input wire logic low_power_stop_in,
  output logic sys_reset_out,
  output logic min_power_out
);
  import bscan_pkg::*;

  typedef struct packed
  {
    logic [IR_LEN-1:0] ir_sr;
    logic [IR_LEN-1:0] ir;
    logic [CHAIN_LEN-1:0] sr;
    logic [UPD_LEN-1:0] upd;
    logic byp;
    logic tlr;
    logic [IN_CELLS-1:0] pin_s1;
    logic [IN_CELLS-1:0] pin_s2;
    logic [OUT_CELLS-1:0] core_s1;
    logic [OUT_CELLS-1:0] core_s2;
    logic chg_tgl;
    logic ex_tgl;
  } tck_regs_type;

  typedef struct packed
  {
    logic tg_s1;
    logic tg_s2;
    logic tg_s3;
    logic ex_s1;
    logic ex_s2;
    logic ex_s3;
    logic [UPD_LEN-1:0] upd;
    logic [IR_LEN-1:0] ir;
    logic tlr;
    logic rin_s1;
    logic rin_s2;
    logic act;
    logic [3:0] ex_cnt;
    logic fire;
    logic sys_rst;
    logic min_pwr;
    logic [OUT_CELLS-1:0] pin_out;
    logic [OUT_CELLS-1:0] pin_oe;
  } clk_regs_type;

  logic [1:0] rst_sync_q;
  logic [1:0] por_sync_q;
  logic rst_n;
  logic tck_rst_n;
  tap_state_type st;
  tck_regs_type t_q;
  tck_regs_type t_d;
  clk_regs_type c_q;
  clk_regs_type c_d;
  logic tdo_q;
  logic tdo_oe_q;
  logic [CHAIN_LEN-2:0] sr_tail;
  logic [CTL_CELLS-1:0] ctl_now;

  // Power-on reset reaches both domains; each releases it on its own clock
  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      rst_sync_q <= SYNC_RESET;
    else
      rst_sync_q <= {rst_sync_q[0], 1'b1};
  end

  always_ff @(posedge tck_in or negedge nrst_in)
  begin
    if (!nrst_in)
      por_sync_q <= SYNC_RESET;
    else
      por_sync_q <= {por_sync_q[0], 1'b1};
  end

  assign rst_n = rst_sync_q[1];
  assign tck_rst_n = por_sync_q[1];

  tap_state_machine u_tap
  (
    .tck_in(tck_in),
    .por_n_in(tck_rst_n),
    .tms_in(tms_in),
    .state_out(st)
  );

  // Test clock side: chain, instruction and the cells that hold pin values
  always_comb
  begin
    t_d = t_q;
    t_d.pin_s1 = pin_in_in;
    t_d.pin_s2 = t_q.pin_s1;
    t_d.core_s1 = core_out_in;
    t_d.core_s2 = t_q.core_s1;
    t_d.tlr = (st == TS_RESET);
    case (st)
      TS_RESET:
      begin
        t_d.ir = IR_RESET;
        t_d.ir_sr = IR_RESET;
        t_d.sr[CTL_CELLS-1:0] = CTL_RESET;
        t_d.upd[CTL_CELLS-1:0] = CTL_RESET;
      end
      TS_CAP_IR: t_d.ir_sr = IR_CAPTURE;
      TS_SH_IR: t_d.ir_sr = {tdi_in, t_q.ir_sr[IR_LEN-1:1]};
      TS_UPD_IR: t_d.ir = t_q.ir_sr;
      TS_CAP_DR:
      begin
        t_d.byp = 1'b0;
        if (bsr_sel(t_q.ir))
        begin
          // Cell kinds by position: control, output latch, input pin
          t_d.sr[CTL_CELLS-1:0] = t_q.upd[CTL_CELLS-1:0];
          t_d.sr[OUT_BASE +: OUT_CELLS] = t_q.core_s2;
          t_d.sr[IN_BASE +: IN_CELLS] = t_q.pin_s2;
        end
      end
      TS_SH_DR:
      begin
        t_d.byp = tdi_in;
        if (bsr_sel(t_q.ir))
          t_d.sr = {tdi_in, t_q.sr[CHAIN_LEN-1:1]};
      end
      TS_UPD_DR:
      begin
        // Clamp leaves the held cells alone, so pins stay put
        if (bsr_sel(t_q.ir))
          t_d.upd = t_q.sr[UPD_LEN-1:0];
      end
      default:
      begin
      end
    endcase
    // Any change of held cells or mode is announced by a toggle
    if (t_d.upd != t_q.upd || t_d.ir != t_q.ir || t_d.tlr != t_q.tlr)
      t_d.chg_tgl = ~t_q.chg_tgl;
    if (t_q.ir == IR_EXTEST && t_d.ir != IR_EXTEST)
      t_d.ex_tgl = ~t_q.ex_tgl;
  end

  // The test clock is never gated, even in low-power stop
  always_ff @(posedge tck_in or negedge tck_rst_n)
  begin
    if (!tck_rst_n)
    begin
      t_q <= '0;
      t_q.ir <= IR_RESET;
      t_q.ir_sr <= IR_RESET;
      t_q.tlr <= 1'b1;
    end
    else
      t_q <= t_d;
  end

  // TDO changes on the falling edge and floats outside shift states
  always_ff @(negedge tck_in or negedge tck_rst_n)
  begin
    if (!tck_rst_n)
    begin
      tdo_q <= 1'b0;
      tdo_oe_q <= 1'b0;
    end
    else
    begin
      tdo_oe_q <= (st == TS_SH_IR) || (st == TS_SH_DR);
      if (st == TS_SH_IR)
        tdo_q <= t_q.ir_sr[0];
      else if (bsr_sel(t_q.ir))
        tdo_q <= t_q.sr[0];
      else
        tdo_q <= t_q.byp;
    end
  end

  // Bus clock side. Held words are copied only after the toggle has
  // crossed, so they are stable; this needs TCK at most a quarter of clk.
  always_comb
  begin
    c_d = c_q;
    c_d.tg_s1 = t_q.chg_tgl;
    c_d.tg_s2 = c_q.tg_s1;
    c_d.tg_s3 = c_q.tg_s2;
    c_d.ex_s1 = t_q.ex_tgl;
    c_d.ex_s2 = c_q.ex_s1;
    c_d.ex_s3 = c_q.ex_s2;
    c_d.rin_s1 = ~system_reset_input_n_in;
    c_d.rin_s2 = c_q.rin_s1;
    if (c_q.tg_s2 ^ c_q.tg_s3)
    begin
      c_d.upd = t_q.upd;
      c_d.ir = t_q.ir;
      c_d.tlr = t_q.tlr;
    end
    c_d.fire = 1'b0;
    if (c_q.ex_s2 ^ c_q.ex_s3)
    begin
      c_d.act = 1'b1;
      c_d.ex_cnt = 4'h1;
    end
    else if (c_q.act)
    begin
      if (c_q.rin_s2)
        c_d.act = 1'b0;
      else if (c_q.ex_cnt == EXIT_FIRE_CLK)
      begin
        c_d.fire = 1'b1;
        c_d.act = 1'b0;
      end
      else
        c_d.ex_cnt = c_q.ex_cnt + 4'h1;
    end
    c_d.sys_rst = (c_q.ir == IR_EXTEST) || (c_q.ir == IR_HIGHZ)
      || c_q.rin_s2 || c_d.fire;
    c_d.min_pwr = low_power_stop_in && c_q.tlr;
    for (int k = 0; k < OUT_CELLS; k++)
    begin
      if (c_q.ir == IR_HIGHZ)
      begin
        c_d.pin_out[k] = core_out_in[k];
        c_d.pin_oe[k] = 1'b0;
      end
      else if (scan_drive(c_q.ir))
      begin
        c_d.pin_out[k] = c_q.upd[OUT_BASE+k];
        c_d.pin_oe[k] = c_q.upd[k % CTL_CELLS];
      end
      else
      begin
        c_d.pin_out[k] = core_out_in[k];
        c_d.pin_oe[k] = core_oe_in[k];
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      c_q <= '0;
      c_q.ir <= IR_RESET;
      c_q.tlr <= 1'b1;
      c_q.sys_rst <= 1'b1;
    end
    else
      c_q <= c_d;
  end

  assign tdo_out = tdo_q;
  assign tdo_oe_out = tdo_oe_q;
  assign pin_out_out = c_q.pin_out;
  assign pin_oe_out = c_q.pin_oe;
  assign sys_reset_out = c_q.sys_rst;
  assign min_power_out = c_q.min_pwr;

  assign sr_tail = t_q.sr[CHAIN_LEN-1:1];
  assign ctl_now = t_q.upd[CTL_CELLS-1:0];

  chk_ir_capture: assert property (
    @(posedge tck_in) disable iff (!tck_rst_n)
    st == TS_CAP_IR |=> t_q.ir_sr == IR_CAPTURE)
    else $error("capture-IR did not load 001");
  chk_ctl_cleared: assert property (
    @(posedge tck_in) disable iff (!tck_rst_n)
    st == TS_RESET |=> (t_q.upd[CTL_CELLS-1:0] == CTL_RESET
      && t_q.sr[CTL_CELLS-1:0] == CTL_RESET))
    else $error("control cells not cleared in reset");
  chk_shift_step: assert property (
    @(posedge tck_in) disable iff (!tck_rst_n)
    (st == TS_SH_DR && bsr_sel(t_q.ir)) |=>
      t_q.sr[CHAIN_LEN-2:0] == $past(sr_tail))
    else $error("scan chain did not step toward TDO");
  chk_ctl_capture: assert property (
    @(posedge tck_in) disable iff (!tck_rst_n)
    (st == TS_CAP_DR && bsr_sel(t_q.ir)) |=>
      t_q.sr[CTL_CELLS-1:0] == $past(ctl_now))
    else $error("control cells lost their value in capture");
  chk_clamp_hold: assert property (
    @(posedge tck_in) disable iff (!tck_rst_n)
    (t_q.ir == IR_CLAMP && $past(t_q.ir) == IR_CLAMP) |-> $stable(t_q.upd))
    else $error("held cells moved under clamp");

  sequence seq_exit_seen;
    c_q.ex_s2 ^ c_q.ex_s3;
  endsequence

  sequence seq_no_reset_in;
    (!c_q.rin_s2) [*8] ##1 !c_q.rin_s2 ##1 !c_q.rin_s2;
  endsequence

  chk_exit_grace: assert property (
    @(posedge clk_in) disable iff (!rst_n)
    seq_exit_seen |=> (!c_q.fire) [*8])
    else $error("self reset fired inside the grace window");
  chk_exit_fire: assert property (
    @(posedge clk_in) disable iff (!rst_n)
    seq_exit_seen ##1 seq_no_reset_in |=> c_q.fire && c_q.sys_rst)
    else $error("self reset missing on the tenth clock");
  chk_test_reset: assert property (
    @(posedge clk_in) disable iff (!rst_n)
    c_q.ir == IR_EXTEST |=> c_q.sys_rst)
    else $error("system reset not held under external test");
  chk_low_power: assert property (
    @(posedge clk_in) disable iff (!rst_n)
    c_q.min_pwr |-> ($past(c_q.tlr) && $past(low_power_stop_in)))
    else $error("minimum power reached outside TAP reset");
  chk_scan_oe: assert property (
    @(posedge clk_in) disable iff (!rst_n)
    scan_drive(c_q.ir) |=> c_q.pin_oe[0] == $past(c_q.upd[0]))
    else $error("pin enable does not follow its control cell");
  chk_highz_pins: assert property (
    @(posedge clk_in) disable iff (!rst_n)
    c_q.ir == IR_HIGHZ |=> c_q.pin_oe == '0)
    else $error("outputs enabled under high impedance");
endmodule

// ===== core/bscan_pkg.sv
// Constants and types shared by the boundary scan chain control block
package bscan_pkg;
  localparam int CHAIN_LEN = 188;
  localparam int CTL_CELLS = 5;
  localparam int OUT_CELLS = 92;
  localparam int IN_CELLS = 91;
  localparam int OUT_BASE = 5;
  localparam int IN_BASE = 97;
  localparam int UPD_LEN = 97;
  localparam int IR_LEN = 3;
  localparam logic [2:0] IR_EXTEST = 3'h0;
  localparam logic [2:0] IR_HIGHZ = 3'h1;
  localparam logic [2:0] IR_SAMPLE = 3'h2;
  localparam logic [2:0] IR_CLAMP = 3'h4;
  localparam logic [2:0] IR_PRIVATE = 3'h6;
  localparam logic [2:0] IR_BYPASS = 3'h7;
  localparam logic [2:0] IR_CAPTURE = 3'h1;
  localparam logic [2:0] IR_RESET = 3'h7;
  localparam logic [4:0] CTL_RESET = 5'h00;
  localparam logic [3:0] EXIT_GRACE_CLKS = 4'h8;
  localparam logic [3:0] EXIT_FIRE_CLK = 4'hA;
  localparam logic [1:0] SYNC_RESET = 2'h0;

  typedef enum logic [3:0] {
    TS_RESET, TS_IDLE, TS_SEL_DR, TS_CAP_DR, TS_SH_DR, TS_EX1_DR,
    TS_PAU_DR, TS_EX2_DR, TS_UPD_DR, TS_SEL_IR, TS_CAP_IR, TS_SH_IR,
    TS_EX1_IR, TS_PAU_IR, TS_EX2_IR, TS_UPD_IR
  } tap_state_type;

  function automatic logic bsr_sel(input logic [2:0] ir);
    bsr_sel = (ir == IR_EXTEST) || (ir == IR_SAMPLE);
  endfunction

  function automatic logic scan_drive(input logic [2:0] ir);
    scan_drive = (ir == IR_EXTEST) || (ir == IR_CLAMP);
  endfunction
endpackage

// ===== core/tap_state_machine.sv
// Sixteen-state test access port controller on the test clock
`timescale 1ns/1ps
module tap_state_machine
(
  input wire logic tck_in,
  input wire logic por_n_in,
  input wire logic tms_in,
  output bscan_pkg::tap_state_type state_out
);
  import bscan_pkg::*;

  typedef struct packed
  {
    tap_state_type st;
  } tap_regs_type;

  tap_regs_type r_q;
  tap_regs_type r_d;

  always_comb
  begin
    r_d = r_q;
    unique case (r_q.st)
      TS_RESET: r_d.st = tms_in ? TS_RESET : TS_IDLE;
      TS_IDLE: r_d.st = tms_in ? TS_SEL_DR : TS_IDLE;
      TS_SEL_DR: r_d.st = tms_in ? TS_SEL_IR : TS_CAP_DR;
      TS_CAP_DR: r_d.st = tms_in ? TS_EX1_DR : TS_SH_DR;
      TS_SH_DR: r_d.st = tms_in ? TS_EX1_DR : TS_SH_DR;
      TS_EX1_DR: r_d.st = tms_in ? TS_UPD_DR : TS_PAU_DR;
      TS_PAU_DR: r_d.st = tms_in ? TS_EX2_DR : TS_PAU_DR;
      TS_EX2_DR: r_d.st = tms_in ? TS_UPD_DR : TS_SH_DR;
      TS_UPD_DR: r_d.st = tms_in ? TS_SEL_DR : TS_IDLE;
      TS_SEL_IR: r_d.st = tms_in ? TS_RESET : TS_CAP_IR;
      TS_CAP_IR: r_d.st = tms_in ? TS_EX1_IR : TS_SH_IR;
      TS_SH_IR: r_d.st = tms_in ? TS_EX1_IR : TS_SH_IR;
      TS_EX1_IR: r_d.st = tms_in ? TS_UPD_IR : TS_PAU_IR;
      TS_PAU_IR: r_d.st = tms_in ? TS_EX2_IR : TS_PAU_IR;
      TS_EX2_IR: r_d.st = tms_in ? TS_UPD_IR : TS_SH_IR;
      TS_UPD_IR: r_d.st = tms_in ? TS_SEL_DR : TS_IDLE;
    endcase
  end

  // Power-on reset pins the controller in reset; TMS has no say then
  always_ff @(posedge tck_in or negedge por_n_in)
  begin
    if (!por_n_in)
      r_q <= '{st: TS_RESET};
    else
      r_q <= r_d;
  end

  assign state_out = r_q.st;

  sequence seq_tms_held;
    tms_in [*5];
  endsequence

  chk_tms_escape: assert property (
    @(posedge tck_in) disable iff (!por_n_in)
    seq_tms_held |=> r_q.st == TS_RESET)
    else $error("five TMS highs did not reach reset");
  chk_reset_stays: assert property (
    @(posedge tck_in) disable iff (!por_n_in)
    (r_q.st == TS_RESET && tms_in) |=> r_q.st == TS_RESET)
    else $error("controller left reset with TMS high");
endmodule

// ===== tb/jtag_tester_model.sv
// Boundary-scan tester model that drives the test access pins
`timescale 1ns/1ps
module jtag_tester_model
(
  output logic tck_out,
  output logic tms_out,
  output logic tdi_out,
  input wire logic tdo_in
);
  // Clock parked low between frames; TMS and TDI rest at pull-up level
  initial
  begin
    tck_out = 1'b0;
    tms_out = 1'b1;
    tdi_out = 1'b1;
  end

  // One test clock; TMS and TDI move well clear of both edges
  task automatic pulse(input logic ms, input logic di, output logic dv);
    #2;
    tms_out = ms;
    tdi_out = di;
    #11;
    dv = tdo_in;
    #3 tck_out = 1'b1;
    #14 tck_out = 1'b0;
  endtask

  // Six TMS-high edges force Test-Logic-Reset from any state
  task automatic go_reset();
    logic dv;
    repeat (6) pulse(1'b1, 1'b1, dv);
  endtask

  // Scan of n bits from Idle or Test-Logic-Reset, ending in Idle
  task automatic scan(input logic ir, input int n, input logic [187:0] din,
    output logic [187:0] dout);
    logic dv;
    dout = '0;
    pulse(1'b0, 1'b1, dv);
    pulse(1'b1, 1'b1, dv);
    if (ir)
      pulse(1'b1, 1'b1, dv);
    pulse(1'b0, 1'b1, dv);
    pulse(1'b0, 1'b1, dv);
    for (int i = 0; i < n; i++)
      pulse(i == n - 1, din[i], dout[i]);
    pulse(1'b1, 1'b1, dv);
    pulse(1'b0, 1'b1, dv);
    tms_out = 1'b1;
  endtask
endmodule

// ===== tb/test_boundary_scan_chain_control.sv
// Self-checking bench for the boundary scan chain control block
`timescale 1ns/1ps
module test_boundary_scan_chain_control;
  import bscan_pkg::*;
  logic clk_in = 1'b0;
  logic nrst_in = 1'b0;
  logic tck, tms, tdi, tdo, tdo_oe, sys_rst, min_pwr;
  logic rst_pin_n = 1'b1;
  logic lps = 1'b0;
  logic [OUT_CELLS-1:0] core_out = {23{4'hA}};
  logic [OUT_CELLS-1:0] core_oe = {23{4'h3}};
  logic [OUT_CELLS-1:0] pin_out, pin_oe;
  logic [IN_CELLS-1:0] ext_lvl = {13{7'h35}};
  logic [IN_CELLS-1:0] wire_lvl, exp_in;
  logic [187:0] dout;
  logic [96:0] pre_a = {{23{4'hC}}, 5'h15};
  logic [96:0] pre_b = {{23{4'h5}}, 5'h0A};
  int mismatches = 0;
  int compares = 0;
  int rises, highs;

  always #2.5 clk_in = ~clk_in;
  // Board drivers yield wherever the device enables its pin
  assign wire_lvl = (pin_oe[90:0] & pin_out[90:0])
    | (~pin_oe[90:0] & ext_lvl);

  jtag_tester_model tester_u (.tck_out(tck), .tms_out(tms), .tdi_out(tdi),
    .tdo_in(tdo));
  boundary_scan_chain_control dut_u (.clk_in(clk_in), .nrst_in(nrst_in),
    .tck_in(tck), .tms_in(tms), .tdi_in(tdi), .tdo_out(tdo),
    .tdo_oe_out(tdo_oe), .core_out_in(core_out), .core_oe_in(core_oe),
    .pin_in_in(wire_lvl), .pin_out_out(pin_out), .pin_oe_out(pin_oe),
    .system_reset_input_n_in(rst_pin_n), .low_power_stop_in(lps),
    .sys_reset_out(sys_rst), .min_power_out(min_pwr));

  task automatic chk(input string what, input logic [191:0] seen, exp);
    compares++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  function automatic logic [91:0] spread(input logic [4:0] ctl);
    for (int k = 0; k < 92; k++)
      spread[k] = ctl[k % 5];
  endfunction

  task automatic ir(input logic [2:0] code);
    tester_u.scan(1'b1, 3, {185'h0, code}, dout);
  endtask

  task automatic dr(input logic [96:0] held);
    tester_u.scan(1'b0, 188, {91'h0, held}, dout);
  endtask

  // Pin copies cross into the bus clock a few cycles after an update
  task automatic settle();
    repeat (12) @(posedge clk_in);
  endtask

  task automatic watch(input int n);
    logic last;
    rises = 0;
    highs = 0;
    last = sys_rst;
    repeat (n)
    begin
      @(posedge clk_in);
      #1;
      rises += (sys_rst && !last);
      highs += (sys_rst && rises > 0);
      last = sys_rst;
    end
  endtask

  task automatic give_verdict();
    $display("Counts: %0d compares, %0d mismatches", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial
  begin
    #400000;
    mismatches++;
    give_verdict();
  end

  initial
  begin
    repeat (5) @(posedge clk_in);
    #1;
    chk("sys_reset in por", sys_rst, 1'b1);
    chk("pin_oe in por", pin_oe, '0);
    chk("tdo_oe in por", tdo_oe, 1'b0);
    @(posedge clk_in);
    nrst_in <= 1'b1;
    lps <= 1'b1;
    settle();
    chk("min_power tap reset", min_pwr, 1'b1);
    chk("pins functional", pin_out, core_out);
    $display("Test power-on done");
    tester_u.go_reset();
    ir(IR_SAMPLE);
    chk("ir capture", dout[2:0], IR_CAPTURE);
    settle();
    chk("min_power blocked", min_pwr, 1'b0);
    exp_in = (core_oe[90:0] & core_out[90:0]) | (~core_oe[90:0] & ext_lvl);
    dr(pre_a);
    chk("ctl capture", dout[4:0], 5'h00);
    chk("out capture", dout[96:5], core_out);
    chk("in capture", dout[187:97], exp_in);
    chk("tdo_oe idle", tdo_oe, 1'b0);
    settle();
    chk("sample quiet oe", pin_oe, core_oe);
    chk("sample quiet rst", sys_rst, 1'b0);
    $display("Test sample done");
    ir(IR_EXTEST);
    settle();
    chk("extest reset", sys_rst, 1'b1);
    chk("preload out", pin_out, pre_a[96:5]);
    chk("preload oe", pin_oe, spread(pre_a[4:0]));
    dr(pre_b);
    chk("ctl recapture", dout[4:0], pre_a[4:0]);
    chk("out recapture", dout[96:5], core_out);
    settle();
    chk("update out", pin_out, pre_b[96:5]);
    chk("update oe", pin_oe, spread(pre_b[4:0]));
    $display("Test extest done");
    @(posedge clk_in) rst_pin_n <= 1'b0;
    ir(IR_BYPASS);
    repeat (2) @(posedge clk_in);
    rst_pin_n <= 1'b1;
    watch(40);
    chk("no self reset", rises, 0);
    ir(IR_EXTEST);
    ir(IR_BYPASS);
    watch(40);
    chk("self reset rise", rises, 1);
    chk("self reset width", highs, 1);
    $display("Test exit done");
    ir(IR_HIGHZ);
    settle();
    chk("highz oe", pin_oe, '0);
    ir(IR_CLAMP);
    settle();
    chk("clamp out", pin_out, pre_b[96:5]);
    chk("clamp oe", pin_oe, spread(pre_b[4:0]));
    tester_u.scan(1'b0, 2, {186'h0, 2'b11}, dout);
    chk("bypass path", dout[1:0], 2'b10);
    settle();
    chk("clamp held", pin_out, pre_b[96:5]);
    $display("Test clamp done");
    tester_u.go_reset();
    settle();
    chk("min_power again", min_pwr, 1'b1);
    chk("reset functional", pin_oe, core_oe);
    ir(IR_SAMPLE);
    dr(pre_a);
    chk("ctl cleared", dout[4:0], 5'h00);
    @(posedge clk_in) lps <= 1'b0;
    settle();
    chk("min_power off", min_pwr, 1'b0);
    $display("Test low-power done");
    give_verdict();
  end
endmodule
